// >>> design/dbc_ddr_device.sv
// device end: per-bank state tracking and command legality checking
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - check only with clock enable high twice, after exit
// - idle after tRP, active after tRCD
// - read/write state until burst ends or stopped
// - deselect and NOP start nothing new
// - idle allows ACTIVE, AUTO REFRESH, MODE REGISTER SET
// - row active allows READ, WRITE, PRECHARGE
// - read allows READ, PRECHARGE, BURST TERMINATE; WRITE only once the burst ended
// - write allows READ, WRITE, PRECHARGE with masking
// - precharging lasts tRP, no same-bank commands
// - row activating lasts tRCD, no same-bank commands
// - auto-precharge access busy until tRP then idle
// - refresh allows only NOP until tRFC
// - mode register set allows only NOP until tMRD
// - precharge all allows only NOP until tRP
// - refresh and mode set need all banks idle
// - terminate hits latest read; precharge-all needs valid banks
// - write after read only once burst ended
// - idle bank n does not restrict bank m
// - busy bank n allows other-bank commands
// - auto-precharge splits into access and precharge
// - access period: other banks get ACTIVE, PRECHARGE only
// - anything else is illegal, needs re-initialisation
// - bank select picks target bank
module dbc_ddr_device (
  input wire logic clk, // 20 MHz clock
  input wire logic resetn, // async reset, low active
  dbc_cmd_if.dev pins, // command pins from the controller
  output dbc_pkg::dbc_banks_type bankState, // state of each bank
  output dbc_pkg::dbc_dev_type devState, // device-wide state
  output logic cmdTaken, // pulse: executable command accepted
  output logic illegalSeen // sticky: illegal command or sequence
);
  import dbc_pkg::*;

  dbc_banks_type next_bankState;
  dbc_dev_type next_devState;
  logic [NBANK-1:0][CNT_W-1:0] cnt, next_cnt;
  logic [CNT_W-1:0] devCnt, next_devCnt;
  logic [CNT_W-1:0] exitCnt, next_exitCnt;
  logic [1:0] lastRd, next_lastRd;
  logic ckePrev;
  logic next_cmdTaken, next_illegalSeen;
  dbc_cmd_type cmd;
  logic window, legal, devFree, allIdle;

  // decode pins and judge the command against the current states
  always_comb begin
    cmd = decodeCmd(pins.csn, pins.rasn, pins.casn, pins.wen);
    window = ckePrev && pins.cke && exitCnt == '0;
    devFree = devState == DV_NORMAL;
    allIdle = 1'b1;
    for (int b = 0; b < NBANK; b++) begin
      allIdle &= (bankState[b] == BK_IDLE);
    end
    legal = cmdLegal(cmd, pins.ba, pins.ap, bankState, devFree, lastRd);
  end

  // device-wide state: refresh, mode set, precharge all, self refresh
  always_comb begin
    next_devState = devState;
    next_devCnt = (devCnt != '0) ? devCnt - 1'b1 : devCnt;
    next_exitCnt = (exitCnt != '0) ? exitCnt - 1'b1 : exitCnt;
    if (devCnt == CNT_W'(1) && devState != DV_SELFREF)
      next_devState = DV_NORMAL;
    if (devState == DV_SELFREF) begin
      if (pins.cke) begin
        next_devState = DV_NORMAL;
        next_exitCnt = XSNR_CYC;
      end
    end else if (ckePrev && !pins.cke && cmd == CMD_REF && allIdle &&
                 devFree) begin
      next_devState = DV_SELFREF;
    end else if (window && legal) begin
      case (cmd)
        CMD_REF: begin
          next_devState = DV_REFRESH;
          next_devCnt = RFC_CYC;
        end
        CMD_MRS: begin
          next_devState = DV_MRS;
          next_devCnt = MRD_CYC;
        end
        CMD_PRE: begin
          if (pins.ap) begin
            next_devState = DV_PREALL;
            next_devCnt = RP_CYC;
          end
        end
        default: next_devState = next_devState;
      endcase
    end
  end

  // per-bank state and timers
  always_comb begin
    next_bankState = bankState;
    next_cnt = cnt;
    next_lastRd = lastRd;
    for (int b = 0; b < NBANK; b++) begin
      if (cnt[b] != '0) begin
        next_cnt[b] = cnt[b] - 1'b1;
      end
      if (cnt[b] == CNT_W'(1)) begin
        case (bankState[b])
          BK_ACTV: next_bankState[b] = BK_ACTIVE;
          BK_READ, BK_WRITE: next_bankState[b] = BK_ACTIVE;
          BK_READAP, BK_WRITEAP: begin
            next_bankState[b] = BK_PRE;
            next_cnt[b] = RP_CYC;
          end
          BK_PRE: next_bankState[b] = BK_IDLE;
          default: next_bankState[b] = bankState[b];
        endcase
      end
    end
    if (window && legal) begin
      case (cmd)
        CMD_ACT: begin
          next_bankState[pins.ba] = BK_ACTV;
          next_cnt[pins.ba] = RCD_CYC;
        end
        CMD_RD, CMD_WR: begin
          // a new column access cuts any burst still running
          for (int b = 0; b < NBANK; b++)
            if (bankState[b] == BK_READ || bankState[b] == BK_WRITE)
              next_bankState[b] = BK_ACTIVE;
          if (cmd == CMD_RD) begin
            next_lastRd = pins.ba;
            next_bankState[pins.ba] = pins.ap ? BK_READAP : BK_READ;
            next_cnt[pins.ba] = BURST_CYC;
          end else begin
            next_bankState[pins.ba] = pins.ap ? BK_WRITEAP : BK_WRITE;
            // write precharge waits for the write recovery time
            next_cnt[pins.ba] = pins.ap ? BURST_CYC + WR_CYC : BURST_CYC;
          end
        end
        CMD_BST: next_bankState[lastRd] = BK_ACTIVE;
        CMD_PRE: begin
          for (int b = 0; b < NBANK; b++)
            if ((pins.ap || b == int'(pins.ba)) &&
                bankState[b] != BK_IDLE) begin
              next_bankState[b] = BK_PRE;
              next_cnt[b] = RP_CYC;
            end
        end
        default: next_bankState = next_bankState;
      endcase
    end
  end

  // status outputs: accepted pulse and sticky illegal flag
  always_comb begin
    next_cmdTaken = window && legal &&
      !(cmd inside {CMD_DESEL, CMD_NOP});
    // only reset (re-initialisation) clears the illegal flag
    next_illegalSeen = illegalSeen || (window && !legal);
    if (exitCnt != '0 && !(cmd inside {CMD_DESEL, CMD_NOP}))
      next_illegalSeen = 1'b1;
  end

  // register device-wide state, its timers and the clock enable history
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      devState <= DV_NORMAL;
      devCnt <= '0;
      exitCnt <= '0;
      ckePrev <= 1'b0;
    end else begin
      devState <= next_devState;
      devCnt <= next_devCnt;
      exitCnt <= next_exitCnt;
      ckePrev <= pins.cke;
    end
  end

  // register bank states, bank timers and the latest read bank
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int b = 0; b < NBANK; b++)
        bankState[b] <= BK_IDLE;
      cnt <= '0;
      lastRd <= 2'h0;
    end else begin
      bankState <= next_bankState;
      cnt <= next_cnt;
      lastRd <= next_lastRd;
    end
  end

  // register status outputs
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cmdTaken <= 1'b0;
      illegalSeen <= 1'b0;
    end else begin
      cmdTaken <= next_cmdTaken;
      illegalSeen <= next_illegalSeen;
    end
  end

endmodule
`default_nettype wire

// >>> design/dbc_pkg.sv
// shared constants, types and legality decode for the bank command logic
package dbc_pkg;

  localparam int NBANK = 4;
  localparam int CNT_W = 4;

  // clock and timing figures in ns, converted to clock cycles
  localparam int T_CK_NS = 50;
  localparam int T_RCD_NS = 15;
  localparam int T_RP_NS = 15;
  localparam int T_WR_NS = 15;
  localparam int T_MRD_NS = 10;
  localparam int T_RFC_NS = 70;
  localparam int T_XSNR_NS = 75;
  localparam int BURST_LEN = 4;

  function automatic int nsToCyc(input int ns);
    int c;
    c = (ns + T_CK_NS - 1) / T_CK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam logic [CNT_W-1:0] RCD_CYC = CNT_W'(nsToCyc(T_RCD_NS));
  localparam logic [CNT_W-1:0] RP_CYC = CNT_W'(nsToCyc(T_RP_NS));
  localparam logic [CNT_W-1:0] WR_CYC = CNT_W'(nsToCyc(T_WR_NS));
  localparam logic [CNT_W-1:0] MRD_CYC = CNT_W'(nsToCyc(T_MRD_NS));
  localparam logic [CNT_W-1:0] RFC_CYC = CNT_W'(nsToCyc(T_RFC_NS));
  localparam logic [CNT_W-1:0] XSNR_CYC = CNT_W'(nsToCyc(T_XSNR_NS));
  localparam logic [CNT_W-1:0] BURST_CYC = CNT_W'(BURST_LEN / 2);

  // decoded command on the pins
  typedef enum logic [3:0] {
    CMD_DESEL = 4'h0, CMD_NOP = 4'h1, CMD_ACT = 4'h2, CMD_RD = 4'h3,
    CMD_WR = 4'h4, CMD_BST = 4'h5, CMD_PRE = 4'h6, CMD_REF = 4'h7,
    CMD_MRS = 4'h8
  } dbc_cmd_type;

  // per-bank state, one-hot
  typedef enum logic [7:0] {
    BK_IDLE = 8'h01, BK_ACTV = 8'h02, BK_ACTIVE = 8'h04, BK_READ = 8'h08,
    BK_WRITE = 8'h10, BK_READAP = 8'h20, BK_WRITEAP = 8'h40,
    BK_PRE = 8'h80
  } dbc_bank_type;

  // device-wide state, one-hot
  typedef enum logic [4:0] {
    DV_NORMAL = 5'h01, DV_REFRESH = 5'h02, DV_MRS = 5'h04,
    DV_PREALL = 5'h08, DV_SELFREF = 5'h10
  } dbc_dev_type;

  typedef dbc_bank_type [NBANK-1:0] dbc_banks_type;

  // pin levels to command
  function automatic dbc_cmd_type decodeCmd(input logic csn, rasn, casn,
                                            wen);
    dbc_cmd_type c;
    case ({csn, rasn, casn, wen})
      4'h7: c = CMD_NOP;
      4'h3: c = CMD_ACT;
      4'h5: c = CMD_RD;
      4'h4: c = CMD_WR;
      4'h6: c = CMD_BST;
      4'h2: c = CMD_PRE;
      4'h1: c = CMD_REF;
      4'h0: c = CMD_MRS;
      default: c = CMD_DESEL;
    endcase
    return c;
  endfunction

  // whether a command is allowed given every bank and the device state
  function automatic logic cmdLegal(input dbc_cmd_type cmd,
                                    input logic [1:0] ba, input logic ap,
                                    input dbc_banks_type st,
                                    input logic devFree,
                                    input logic [1:0] lastRd);
    logic allIdle, anyRead, apOther, canPre;
    allIdle = 1'b1;
    anyRead = 1'b0;
    apOther = 1'b0;
    canPre = 1'b1;
    for (int b = 0; b < NBANK; b++) begin
      allIdle &= (st[b] == BK_IDLE);
      anyRead |= (st[b] == BK_READ);
      if (b != int'(ba) && (st[b] == BK_READAP || st[b] == BK_WRITEAP))
        apOther = 1'b1;
      if (!(st[b] inside {BK_IDLE, BK_ACTIVE, BK_READ, BK_WRITE}))
        canPre = 1'b0;
    end
    case (cmd)
      CMD_DESEL, CMD_NOP: return 1'b1;
      CMD_ACT: return devFree && st[ba] == BK_IDLE;
      CMD_RD: return devFree && !apOther &&
        (st[ba] inside {BK_ACTIVE, BK_READ, BK_WRITE});
      CMD_WR: return devFree && !apOther && !anyRead &&
        (st[ba] inside {BK_ACTIVE, BK_WRITE});
      CMD_BST: return devFree && st[lastRd] == BK_READ;
      CMD_PRE: return devFree && (ap ? canPre :
        (st[ba] inside {BK_IDLE, BK_ACTIVE, BK_READ, BK_WRITE}));
      CMD_REF, CMD_MRS: return devFree && allIdle;
      default: return 1'b0;
    endcase
  endfunction

endpackage

// >>> design/dbc_cmd_if.sv
// command pins between the memory controller and the ddr device
`timescale 1ns/1ps
`default_nettype none
interface dbc_cmd_if;
  logic cke; // clock enable
  logic csn; // chip select, low active
  logic rasn; // row strobe, low active
  logic casn; // column strobe, low active
  logic wen; // write enable, low active
  logic [1:0] ba; // bank select
  logic ap; // auto precharge / precharge-all address bit

  modport dev (input cke, csn, rasn, casn, wen, ba, ap);
  modport ctl (output cke, csn, rasn, casn, wen, ba, ap);
endinterface
`default_nettype wire

// >>> design/dbc_ddr_controller.sv
// controller end: issues user commands only when the bank model allows
`timescale 1ns/1ps
`default_nettype none
module dbc_ddr_controller (
  input wire logic clk, // 20 MHz clock
  input wire logic resetn, // async reset, low active
  dbc_cmd_if.ctl pins, // command pins to the device
  input wire logic reqValid, // user wants a command issued
  input wire dbc_pkg::dbc_cmd_type reqCmd, // command to issue
  input wire logic [1:0] reqBank, // target bank
  input wire logic reqAp, // auto precharge / all-bank bit
  output logic reqDone // pulse: request driven on pins
);
  import dbc_pkg::*;

  dbc_banks_type st, next_st;
  logic [NBANK-1:0][CNT_W-1:0] cnt, next_cnt;
  logic [CNT_W-1:0] devCnt, next_devCnt;
  logic [1:0] lastRd, next_lastRd;
  logic go;
  logic [3:0] next_pins;

  // shadow of the device bank states, one cycle ahead of the device
  always_comb begin
    go = reqValid && !reqDone &&
      cmdLegal(reqCmd, reqBank, reqAp, st, devCnt == '0, lastRd);
    next_st = st;
    next_cnt = cnt;
    next_devCnt = (devCnt != '0) ? devCnt - 1'b1 : devCnt;
    next_lastRd = lastRd;
    for (int b = 0; b < NBANK; b++) begin
      if (cnt[b] != '0)
        next_cnt[b] = cnt[b] - 1'b1;
      if (cnt[b] == CNT_W'(1)) begin
        case (st[b])
          BK_ACTV, BK_READ, BK_WRITE: next_st[b] = BK_ACTIVE;
          BK_READAP, BK_WRITEAP: begin
            next_st[b] = BK_PRE;
            next_cnt[b] = RP_CYC;
          end
          default: next_st[b] = BK_IDLE;
        endcase
      end
    end
    if (go) begin
      case (reqCmd)
        CMD_ACT: begin
          next_st[reqBank] = BK_ACTV;
          next_cnt[reqBank] = RCD_CYC;
        end
        CMD_RD, CMD_WR: begin
          for (int b = 0; b < NBANK; b++)
            if (st[b] == BK_READ || st[b] == BK_WRITE)
              next_st[b] = BK_ACTIVE;
          if (reqCmd == CMD_RD) begin
            next_lastRd = reqBank;
            next_st[reqBank] = reqAp ? BK_READAP : BK_READ;
            next_cnt[reqBank] = BURST_CYC;
          end else begin
            next_st[reqBank] = reqAp ? BK_WRITEAP : BK_WRITE;
            next_cnt[reqBank] = reqAp ? BURST_CYC + WR_CYC : BURST_CYC;
          end
        end
        CMD_BST: next_st[lastRd] = BK_ACTIVE;
        CMD_PRE: begin
          for (int b = 0; b < NBANK; b++)
            if ((reqAp || b == int'(reqBank)) && st[b] != BK_IDLE) begin
              next_st[b] = BK_PRE;
              next_cnt[b] = RP_CYC;
            end
          if (reqAp)
            next_devCnt = RP_CYC;
        end
        CMD_REF: next_devCnt = RFC_CYC;
        CMD_MRS: next_devCnt = MRD_CYC;
        default: next_devCnt = next_devCnt;
      endcase
    end
    // pins order csn rasn casn wen
    case (reqCmd)
      CMD_NOP: next_pins = 4'h7;
      CMD_ACT: next_pins = 4'h3;
      CMD_RD: next_pins = 4'h5;
      CMD_WR: next_pins = 4'h4;
      CMD_BST: next_pins = 4'h6;
      CMD_PRE: next_pins = 4'h2;
      CMD_REF: next_pins = 4'h1;
      CMD_MRS: next_pins = 4'h0;
      default: next_pins = 4'hf;
    endcase
    if (!go)
      next_pins = 4'hf;
  end

  // register shadow state and command pins
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int b = 0; b < NBANK; b++)
        st[b] <= BK_IDLE;
      cnt <= '0;
      devCnt <= '0;
      lastRd <= 2'h0;
      {pins.csn, pins.rasn, pins.casn, pins.wen} <= 4'hf;
      pins.ba <= 2'h0;
      pins.ap <= 1'b0;
      pins.cke <= 1'b0;
      reqDone <= 1'b0;
    end else begin
      st <= next_st;
      cnt <= next_cnt;
      devCnt <= next_devCnt;
      lastRd <= next_lastRd;
      {pins.csn, pins.rasn, pins.casn, pins.wen} <= next_pins;
      pins.ba <= go ? reqBank : pins.ba;
      pins.ap <= go ? reqAp : pins.ap;
      pins.cke <= 1'b1;
      reqDone <= go;
    end
  end

endmodule
`default_nettype wire

// >>> bench/dbc_sva.sv
// assertions on the command pins and device status of the main pair
`timescale 1ns/1ps
`default_nettype none
module dbc_sva (
  input wire logic clk, // clock
  input wire logic resetn, // async reset, low active
  input wire logic cke, // clock enable
  input wire logic csn, // chip select
  input wire logic rasn, // row strobe
  input wire logic casn, // column strobe
  input wire logic wen, // write enable
  input wire logic [1:0] ba, // bank
  input wire logic ap, // auto precharge bit
  input wire dbc_pkg::dbc_banks_type bankState, // bank states
  input wire dbc_pkg::dbc_dev_type devState, // device state
  input wire logic cmdTaken, // command accepted
  input wire logic illegalSeen, // illegal flag
  input wire logic reqDone // controller issued
);
  import dbc_pkg::*;
  logic ckePrev;
  logic anyRead;
  logic allIdle;
  // clock enable seen at the previous edge
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) ckePrev <= 1'b0;
    else ckePrev <= cke;
  end
  // summary of all banks
  always_comb begin
    anyRead = 1'b0;
    allIdle = 1'b1;
    for (int b = 0; b < NBANK; b++) begin
      anyRead |= (bankState[b] == BK_READ);
      allIdle &= (bankState[b] == BK_IDLE);
    end
  end
  // what the device judges at this edge
  wire judged = cke && ckePrev && !csn;
  wire [2:0] cmd3 = {rasn, casn, wen};
  wire exec = judged && cmd3 != 3'h7;
  wire actCmd = judged && cmd3 == 3'h3;
  wire rdCmd = judged && cmd3 == 3'h5;
  wire wrCmd = judged && cmd3 == 3'h4;
  wire preCmd = judged && cmd3 == 3'h2;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence rdOpen;
    rdCmd && !ap ##1 1'b1 ##1 !exec;
  endsequence
  sequence refBusy;
    devState == DV_REFRESH [*2];
  endsequence
  cmd_taken_a: assert property (1'b1 |=> cmdTaken == $past(exec))
    else $error("accept pulse does not follow the pins");
  act_timing_a: assert property (actCmd |=>
    bankState[$past(ba)] == BK_ACTV ##1
    bankState[$past(ba, 2)] == BK_ACTIVE)
    else $error("activate timing wrong");
  pre_timing_a: assert property (preCmd && !ap &&
    bankState[ba] != BK_IDLE |=> bankState[$past(ba)] == BK_PRE ##1
    bankState[$past(ba, 2)] == BK_IDLE)
    else $error("precharge timing wrong");
  rd_burst_a: assert property (rdOpen |->
    bankState[$past(ba, 2)] == BK_READ ##1
    bankState[$past(ba, 3)] == BK_ACTIVE)
    else $error("read burst length wrong");
  ref_hold_a: assert property (judged && cmd3 == 3'h1 |=>
    refBusy ##1 devState == DV_NORMAL)
    else $error("refresh period wrong");
  mrs_hold_a: assert property (judged && cmd3 == 3'h0 |=>
    devState == DV_MRS ##1 devState == DV_NORMAL)
    else $error("mode set period wrong");
  preall_hold_a: assert property (preCmd && ap |=>
    devState == DV_PREALL ##1 (devState == DV_NORMAL && allIdle))
    else $error("precharge all period wrong");
  done_pins_a: assert property (reqDone |-> !csn ##1 csn)
    else $error("issued command not one cycle on pins");
  act_legal_a: assert property (actCmd |-> bankState[ba] == BK_IDLE)
    else $error("activate to a busy bank");
  wr_after_rd_a: assert property (wrCmd |-> !anyRead)
    else $error("write during a read burst");
  no_illegal_a: assert property (!illegalSeen)
    else $error("device flagged the controller");
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
// bench: controller and device joined, plus a rule-breaking driver
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dbc_pkg::*;
  typedef struct packed {
    logic dev;
    logic [1:0] bank;
    logic [7:0] val;
  } dbc_exp_type;
  logic clk;
  logic resetn;
  logic reqValid;
  dbc_cmd_type reqCmd;
  logic [1:0] reqBank;
  logic reqAp;
  logic reqDone;
  dbc_banks_type bankState;
  dbc_banks_type bankStateB;
  dbc_dev_type devState;
  logic cmdTaken;
  logic cmdTakenB;
  logic illegalSeen;
  logic illegalSeenB;
  logic [31:0] rnd;
  int bad_count;
  int check_count;
  dbc_exp_type expQ[$];
  dbc_cmd_if cmdBus();
  dbc_cmd_if badBus();
  dbc_ddr_controller dbc_ddr_controller_inst (.clk(clk), .resetn(resetn),
    .pins(cmdBus), .reqValid(reqValid), .reqCmd(reqCmd),
    .reqBank(reqBank), .reqAp(reqAp), .reqDone(reqDone));
  dbc_ddr_device dbc_ddr_device_inst (.clk(clk), .resetn(resetn),
    .pins(cmdBus), .bankState(bankState), .devState(devState),
    .cmdTaken(cmdTaken), .illegalSeen(illegalSeen));
  dbc_ddr_device dbc_ddr_device_inst_b (.clk(clk), .resetn(resetn),
    .pins(badBus), .bankState(bankStateB), .devState(),
    .cmdTaken(cmdTakenB), .illegalSeen(illegalSeenB));
  dbc_sva dbc_sva_inst (.clk(clk), .resetn(resetn), .cke(cmdBus.cke),
    .csn(cmdBus.csn), .rasn(cmdBus.rasn), .casn(cmdBus.casn),
    .wen(cmdBus.wen), .ba(cmdBus.ba), .ap(cmdBus.ap),
    .bankState(bankState), .devState(devState), .cmdTaken(cmdTaken),
    .illegalSeen(illegalSeen), .reqDone(reqDone));
  // 20 MHz clock
  always #25 clk = ~clk;
  function automatic logic [31:0] lfsrNext(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic mism(input string n, input logic [7:0] e, logic [7:0] g);
    bad_count++;
    $display("wrong value %s expected %h seen %h", n, e, g);
  endtask
  task automatic cmp_bank(input string n, input dbc_bank_type e, g);
    check_count++;
    if (g !== e) mism(n, e, g);
  endtask
  task automatic cmp_dev(input string n, input dbc_dev_type e, g);
    check_count++;
    if (g !== e) mism(n, {3'h0, e}, {3'h0, g});
  endtask
  task automatic cmp_flag(input string n, input logic e, g);
    check_count++;
    if (g !== e) mism(n, {7'h0, e}, {7'h0, g});
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // place one request, note its result, wait for the issue pulse
  task automatic issue(input dbc_cmd_type c, input logic [1:0] b,
                       input logic a, input dbc_exp_type e);
    int n;
    @(posedge clk);
    reqValid <= 1'b1;
    reqCmd <= c;
    reqBank <= b;
    reqAp <= a;
    expQ.push_back(e);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (reqDone !== 1'b1 && n < 300);
    if (n >= 300) begin
      bad_count++;
      give_verdict();
    end
  endtask
  task automatic quiet;
    @(posedge clk);
    reqValid <= 1'b0;
    repeat (12) @(posedge clk);
  endtask
  // drive the second device directly, then let the edge land
  task automatic badPins(input logic [3:0] p, input logic [1:0] b);
    @(posedge clk);
    {badBus.csn, badBus.rasn, badBus.casn, badBus.wen} <= p;
    badBus.ba <= b;
    #1;
  endtask
  // compare each accepted command with the oldest note
  initial begin
    dbc_exp_type e;
    forever begin
      @(posedge clk);
      #1;
      if (cmdTaken === 1'b1) begin
        if (expQ.size() == 0) begin
          mism("note queue", 8'h1, 8'h0);
        end else begin
          e = expQ.pop_front();
          if (e.dev) begin
            cmp_dev("devState", dbc_dev_type'(e.val[4:0]),
              devState);
          end else begin
            cmp_bank("bankState", dbc_bank_type'(e.val),
              bankState[e.bank]);
          end
        end
      end
    end
  end
  // overall time limit
  initial begin
    #2000000;
    bad_count++;
    give_verdict();
  end
  // main sequence
  initial begin
    logic [1:0] b;
    clk = 1'b0;
    resetn = 1'b0;
    reqValid = 1'b0;
    reqCmd = CMD_NOP;
    reqBank = 2'h0;
    reqAp = 1'b0;
    badBus.cke = 1'b0;
    {badBus.csn, badBus.rasn, badBus.casn, badBus.wen} = 4'hf;
    badBus.ba = 2'h0;
    badBus.ap = 1'b0;
    bad_count = 0;
    check_count = 0;
    rnd = 32'h67f4042a;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    badBus.cke <= 1'b1;
    {badBus.csn, badBus.rasn, badBus.casn, badBus.wen} <= 4'h5;
    badPins(4'h7, 2'h0);
    cmp_flag("illegalSeen", 1'b0, illegalSeenB);
    badPins(4'h3, 2'h2);
    cmp_flag("cmdTaken", 1'b0, cmdTakenB);
    badPins(4'h5, 2'h2);
    cmp_flag("cmdTaken", 1'b1, cmdTakenB);
    cmp_bank("bankState", BK_ACTV, bankStateB[2]);
    badPins(4'h7, 2'h0);
    cmp_flag("illegalSeen", 1'b1, illegalSeenB);
    cmp_bank("bankState", BK_ACTIVE, bankStateB[2]);
    badPins(4'h7, 2'h0);
    cmp_flag("illegalSeen", 1'b1, illegalSeenB);
    $display("test fault driver done");
    for (int i = 0; i < 4; i++) begin
      rnd = lfsrNext(rnd);
      b = rnd[1:0];
      issue(CMD_ACT, b, 1'b0, {1'b0, b, BK_ACTV});
      issue(CMD_RD, b, 1'b0, {1'b0, b, BK_READ});
      issue(CMD_WR, b, 1'b0, {1'b0, b, BK_WRITE});
      issue(CMD_PRE, b, 1'b0, {1'b0, b, BK_PRE});
    end
    quiet();
    $display("test bank cycle done");
    issue(CMD_ACT, 2'h0, 1'b0, {1'b0, 2'h0, BK_ACTV});
    issue(CMD_ACT, 2'h1, 1'b0, {1'b0, 2'h1, BK_ACTV});
    issue(CMD_WR, 2'h0, 1'b1, {1'b0, 2'h0, BK_WRITEAP});
    issue(CMD_RD, 2'h1, 1'b0, {1'b0, 2'h1, BK_READ});
    issue(CMD_BST, 2'h3, 1'b0, {1'b0, 2'h1, BK_ACTIVE});
    issue(CMD_PRE, 2'h1, 1'b0, {1'b0, 2'h1, BK_PRE});
    quiet();
    $display("test two banks done");
    issue(CMD_PRE, 2'h2, 1'b1, {1'b1, 2'h0, 3'h0, DV_PREALL});
    issue(CMD_REF, 2'h0, 1'b0, {1'b1, 2'h0, 3'h0, DV_REFRESH});
    issue(CMD_MRS, 2'h0, 1'b0, {1'b1, 2'h0, 3'h0, DV_MRS});
    quiet();
    $display("test device wide done");
    cmp_flag("note queue empty", 1'b1, expQ.size() == 0);
    cmp_flag("illegalSeen", 1'b0, illegalSeen);
    give_verdict();
  end
endmodule
`default_nettype wire
